// ==== biphase_audio_checker_sva.sv ====
// Concurrent checks on the transmitter's frame timing and line output.
`timescale 1ns/1ps
`default_nettype none
module biphase_audio_checker
  import biphase_audio_pkg::*;
(
  input wire logic       i_clk,
  input wire logic       i_rstn,
  input wire logic       o_sample_ready,
  input wire logic [7:0] o_frame_index,
  input wire logic       o_block_start,
  input wire logic       o_digital_audio_serial_out
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);
  logic [7:0] last_idx_reg;
  logic       seen_reg;
  // Remembers the index shown at the previous frame start.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      last_idx_reg <= FRAME_RESET;
      seen_reg <= 1'b0;
    end else if (o_sample_ready) begin
      last_idx_reg <= o_frame_index;
      seen_reg <= 1'b1;
    end
  end
  a_line_holds: assert property ($changed(o_digital_audio_serial_out) |=> $stable(o_digital_audio_serial_out))
    else $error("line changed on consecutive clocks");
  a_ready_gap: assert property (o_sample_ready |=> !o_sample_ready [*8])
    else $error("frame starts too close");
  a_pre_toggle: assert property (o_sample_ready |=> $changed(o_digital_audio_serial_out))
    else $error("no transition at subframe start");
  a_blk_after: assert property (o_sample_ready && o_frame_index == FRAME_RESET |=> o_block_start)
    else $error("block start missing");
  a_blk_cause: assert property (o_block_start |-> $past(o_sample_ready) && $past(o_frame_index) == FRAME_RESET)
    else $error("block start without frame zero");
  a_idx_range: assert property (o_frame_index <= FRAME_LAST)
    else $error("frame index out of range");
  // The index steps on the last tick of subframe B; the next tick starts the frame.
  a_idx_stable: assert property ($changed(o_frame_index) |-> ##[1:20] o_sample_ready)
    else $error("frame index moved mid-frame");
  a_idx_wrap: assert property (o_sample_ready && seen_reg |->
    o_frame_index == ((last_idx_reg == FRAME_LAST) ? FRAME_RESET : last_idx_reg + 8'h01))
    else $error("frame index did not step");
endmodule
bind biphase_audio_transmitter biphase_audio_checker u_chk (.i_clk(i_clk), .i_rstn(i_rstn),
  .o_sample_ready(o_sample_ready), .o_frame_index(o_frame_index), .o_block_start(o_block_start),
  .o_digital_audio_serial_out(o_digital_audio_serial_out));
`default_nettype wire

// ==== biphase_audio_pkg.sv ====
// Constants shared by the biphase-mark audio transmitter.
package biphase_audio_pkg;

  localparam int unsigned CLK_HZ            = 100_000_000;
  localparam int unsigned SAMPLE_RATE_HZ    = 48_000;
  localparam int unsigned SLOTS_PER_SUB     = 32;
  localparam int unsigned UI_PER_SLOT       = 2;
  localparam int unsigned SUBS_PER_FRAME    = 2;
  localparam int unsigned UI_PER_FRAME      = SLOTS_PER_SUB * UI_PER_SLOT * SUBS_PER_FRAME;
  localparam int unsigned FRAMES_PER_BLOCK  = 192;
  localparam int unsigned AUDIO_MAX_W       = 24;

  localparam logic [4:0] AUDIO_LSB_SLOT     = 5'h04;
  localparam logic [4:0] AUDIO_MSB_SLOT     = 5'h1B;
  localparam logic [4:0] VALIDITY_SLOT      = 5'h1C;
  localparam logic [4:0] USER_SLOT          = 5'h1D;
  localparam logic [4:0] STATUS_SLOT        = 5'h1E;
  localparam logic [4:0] PARITY_SLOT        = 5'h1F;
  localparam logic [4:0] PREAMBLE_END_SLOT  = 5'h03;
  localparam logic [5:0] UI_LAST_IN_SUB     = 6'h3F;
  localparam logic [7:0] FRAME_LAST         = 8'hBF;

  // Preamble patterns, first unit interval in the MSB, for a previous level of 0.
  localparam logic [7:0] PRE_B              = 8'hE8;
  localparam logic [7:0] PRE_M              = 8'hE2;
  localparam logic [7:0] PRE_W              = 8'hE4;

  localparam logic [31:0] ACC_RESET         = 32'h0000_0000;
  localparam logic [7:0]  FRAME_RESET       = 8'h00;
  localparam logic [5:0]  UI_RESET          = 6'h00;

endpackage

// ==== biphase_audio_transmitter.sv ====
// Biphase-mark stereo audio transmitter: block, frame and subframe sequencing and line coding.
`timescale 1ns/1ps
`default_nettype none
module biphase_audio_transmitter
  import biphase_audio_pkg::*;
#(
  parameter int unsigned SAMPLE_W    = AUDIO_MAX_W,
  parameter int unsigned CLK_FREQ_HZ = CLK_HZ,
  parameter int unsigned SAMPLE_HZ   = SAMPLE_RATE_HZ
) (
  input  wire logic                i_clk,
  input  wire logic                i_rstn,
  input  wire logic [SAMPLE_W-1:0] i_left,
  input  wire logic [SAMPLE_W-1:0] i_right,
  input  wire logic                i_sample_valid,
  input  wire logic                i_user_a,
  input  wire logic                i_user_b,
  input  wire logic                i_status_a,
  input  wire logic                i_status_b,
  output logic                     o_sample_ready,
  output logic [7:0]               o_frame_index,
  output logic                     o_block_start,
  output logic                     o_digital_audio_serial_out
);

  ui_tick_if ui ();

  ui_tick_gen #(
    .CLK_FREQ_HZ (CLK_FREQ_HZ),
    .SAMPLE_HZ   (SAMPLE_HZ)
  ) u_ui_tick_gen (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .ui     (ui)
  );

  // Position of the unit interval about to be driven.
  logic [5:0]  ui_reg;
  logic        sub_b_reg;
  logic [7:0]  frame_reg;
  logic        level_reg;
  logic        pol_reg;
  logic        block_start_reg;

  // Sample and side bits held for the whole frame.
  logic [23:0] left_reg;
  logic [23:0] right_reg;
  logic        invalid_reg;
  logic        user_a_reg;
  logic        user_b_reg;
  logic        status_a_reg;
  logic        status_b_reg;

  logic [5:0]  ui_next;
  logic        sub_b_next;
  logic [7:0]  frame_next;
  logic        level_next;

  logic        frame_start;
  logic        sub_end;
  logic        block_end;
  logic [4:0]  slot;
  logic        second_half;
  logic        in_preamble;
  logic [7:0]  pre_pat;
  logic        pre_bit;
  logic        pol_now;
  logic [23:0] audio_left;
  logic [23:0] audio_right;
  logic [23:0] audio_word;
  logic        user_bit;
  logic        status_bit;
  logic        parity_bit;
  logic [31:0] sub_word;
  logic        data_bit;

  assign slot        = ui_reg[5:1];
  assign second_half = ui_reg[0];
  assign in_preamble = (slot <= PREAMBLE_END_SLOT);
  assign sub_end     = (ui_reg == UI_LAST_IN_SUB);
  assign block_end   = sub_end && sub_b_reg && (frame_reg == FRAME_LAST);
  assign frame_start = ui.tick && (ui_reg == UI_RESET) && !sub_b_reg;

  // The transmitter asks for the next stereo pair as each frame begins.
  assign o_sample_ready = frame_start;

  // Preamble choice by subframe and position in the block.
  assign pre_pat = sub_b_reg ? PRE_W :
                   (frame_reg == FRAME_RESET) ? PRE_B : PRE_M;

  // Patterns are stored for a previous level of 0 and inverted after a high end.
  assign pol_now = (ui_reg == UI_RESET) ? level_reg : pol_reg;
  assign pre_bit = pre_pat[3'd7 - ui_reg[2:0]] ^ pol_now;

  // Short words are left aligned so their MSB still lands in the last audio slot.
  assign audio_left  = 24'(left_reg);
  assign audio_right = 24'(right_reg);
  assign audio_word  = sub_b_reg ? audio_right : audio_left;
  assign user_bit    = sub_b_reg ? user_b_reg : user_a_reg;
  assign status_bit  = sub_b_reg ? status_b_reg : status_a_reg;

  // Even parity over slots 4 to 31 keeps every subframe ending at the same polarity.
  assign parity_bit  = ^{status_bit, user_bit, invalid_reg, audio_word};

  // Bit n of the word is slot n; audio LSB sits in the first audio slot.
  assign sub_word = {parity_bit, status_bit, user_bit, invalid_reg,
                     audio_word, 4'h0};
  assign data_bit = sub_word[slot];

  // Line level for the unit interval about to be driven.
  assign level_next = in_preamble ? pre_bit :
                      !second_half ? !level_reg :
                      (data_bit ? !level_reg : level_reg);

  assign ui_next    = ui_reg + 6'h01;
  assign sub_b_next = sub_end ? !sub_b_reg : sub_b_reg;
  assign frame_next = block_end ? FRAME_RESET :
                      (sub_end && sub_b_reg) ? (frame_reg + 8'h01) : frame_reg;

  // Position counters advance once per unit interval.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      ui_reg    <= UI_RESET;
      sub_b_reg <= 1'b0;
      frame_reg <= FRAME_RESET;
    end else if (ui.tick) begin
      ui_reg    <= ui_next;
      sub_b_reg <= sub_b_next;
      frame_reg <= frame_next;
    end
  end

  // Line driver and preamble polarity.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      level_reg <= 1'b0;
      pol_reg   <= 1'b0;
    end else if (ui.tick) begin
      level_reg <= level_next;
      pol_reg   <= pol_now;
    end
  end

  // Frame data capture; a missing sample repeats the last one flagged unreliable.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      left_reg     <= 24'h00_0000;
      right_reg    <= 24'h00_0000;
      invalid_reg  <= 1'b1;
      user_a_reg   <= 1'b0;
      user_b_reg   <= 1'b0;
      status_a_reg <= 1'b0;
      status_b_reg <= 1'b0;
    end else if (frame_start) begin
      if (i_sample_valid) begin
        left_reg  <= 24'(i_left)  << (AUDIO_MAX_W - SAMPLE_W);
        right_reg <= 24'(i_right) << (AUDIO_MAX_W - SAMPLE_W);
      end
      invalid_reg  <= !i_sample_valid;
      user_a_reg   <= i_user_a;
      user_b_reg   <= i_user_b;
      status_a_reg <= i_status_a;
      status_b_reg <= i_status_b;
    end
  end

  // One-cycle marker on the clock after the first frame of a block begins.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      block_start_reg <= 1'b0;
    end else begin
      block_start_reg <= frame_start && (frame_reg == FRAME_RESET);
    end
  end

  assign o_frame_index              = frame_reg;
  assign o_block_start              = block_start_reg;
  assign o_digital_audio_serial_out = level_reg;

endmodule
`default_nettype wire

// ==== biphase_rx_model.sv ====
// Receiver model that samples the line on every second falling clock edge, one unit interval at this bench's rate.
`timescale 1ns/1ps
`default_nettype none
module biphase_rx_model (
  input  wire logic    i_clk,
  input  wire logic    i_line,
  input  wire logic    i_frame_start,
  output logic [127:0] o_frame
);
  logic sof_seen = 1'b0;
  logic ph       = 1'b0;
  // Frame start stands in for preamble lock, so sampling phase is known.
  always @(posedge i_clk) sof_seen <= i_frame_start;
  always @(negedge i_clk) begin
    if (sof_seen) ph = 1'b0;
    if (!ph) o_frame = {o_frame[126:0], i_line};
    ph = ~ph;
  end
endmodule
`default_nettype wire

// ==== tb_biphase_audio_transmitter.sv ====
// Self-checking bench for the biphase-mark audio transmitter.
`timescale 1ns/1ps
`default_nettype none
module tb_biphase_audio_transmitter;
  import biphase_audio_pkg::*;
  logic         i_clk, i_rstn, i_sample_valid, i_user_a, i_user_b, i_status_a, i_status_b;
  logic [23:0]  i_left, i_right, held_l, held_r;
  logic         o_sample_ready, o_block_start, o_line, lvl, blk_q, have_exp;
  logic [7:0]   o_frame_index;
  logic [127:0] rx_frame, exp_frame;
  logic [31:0]  r;
  int           n_fail = 0, n_checks = 0, frames = 0, cycles = 0;

  biphase_audio_transmitter #(.SAMPLE_W(24), .SAMPLE_HZ(390_625)) u_dut (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_left(i_left), .i_right(i_right),
    .i_sample_valid(i_sample_valid), .i_user_a(i_user_a), .i_user_b(i_user_b),
    .i_status_a(i_status_a), .i_status_b(i_status_b), .o_sample_ready(o_sample_ready),
    .o_frame_index(o_frame_index), .o_block_start(o_block_start),
    .o_digital_audio_serial_out(o_line));
  biphase_rx_model u_rx (.i_clk(i_clk), .i_line(o_line), .i_frame_start(o_sample_ready), .o_frame(rx_frame));

  always #5 i_clk = ~i_clk;

  task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict;
    if (n_fail == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  // One subframe of 64 unit intervals; l carries the line level across.
  function automatic logic [63:0] enc(input logic [7:0] pre, input logic [23:0] s, input logic v,
                                      input logic u, input logic c, inout logic l);
    logic [31:0] d;
    logic [63:0] o;
    d = {1'b0, c, u, ~v, s, 4'h0};
    d[31] = ^d[30:4];
    o[63:56] = pre ^ {8{l}};
    l = o[56];
    for (int i = 4; i < 32; i++) begin
      o[63-2*i] = ~l;
      o[62-2*i] = ~l ^ d[i];
      l = o[62-2*i];
    end
    return o;
  endfunction

  initial begin
    {i_clk, i_rstn, i_sample_valid, i_user_a, i_user_b, i_status_a, i_status_b} = 7'h00;
    {i_left, i_right, held_l, held_r} = 96'h0;
    {lvl, blk_q, have_exp} = 3'h0;
    r = 32'h0000_003D;
    repeat (2) @(posedge i_clk);
    @(negedge i_clk) i_rstn = 1'b1;
    check("reset line", 128'(o_line), 128'h0);
    wait (frames >= 194);
    give_verdict();
  end

  always @(negedge i_clk) begin
    check("block start", 128'(o_block_start), 128'(blk_q));
    blk_q = 1'b0;
    r = lfsr(r);
    {i_sample_valid, i_user_a, i_user_b, i_status_a, i_status_b} = r[31:27];
    i_left = r[23:0];
    r = lfsr(r);
    i_right = r[23:0];
    if (frames == 3) {i_sample_valid, i_left, i_right} = 49'h1_FFFF_FF80_0000;
    if (o_sample_ready && i_rstn) begin
      if (have_exp) check("frame", rx_frame, exp_frame);
      check("index", 128'(o_frame_index), 128'(frames % 192));
      blk_q = (frames % 192 == 0);
      if (i_sample_valid) begin
        held_l = i_left;
        held_r = i_right;
      end
      exp_frame[127:64] = enc(blk_q ? PRE_B : PRE_M, held_l, i_sample_valid, i_user_a, i_status_a, lvl);
      exp_frame[63:0] = enc(PRE_W, held_r, i_sample_valid, i_user_b, i_status_b, lvl);
      have_exp = 1'b1;
      frames++;
    end
  end

  always @(posedge i_clk) begin
    cycles++;
    if (cycles >= 60000) begin
      n_fail++;
      give_verdict();
    end
  end
endmodule
`default_nettype wire

// ==== ui_tick_gen.sv ====
// Fractional divider giving one enable pulse per unit interval.
`timescale 1ns/1ps
`default_nettype none
module ui_tick_gen
  import biphase_audio_pkg::*;
#(
  parameter int unsigned CLK_FREQ_HZ = CLK_HZ,
  parameter int unsigned SAMPLE_HZ   = SAMPLE_RATE_HZ
) (
  input  wire logic i_clk,
  input  wire logic i_rstn,
  ui_tick_if.src    ui
);

  // The unit interval rate depends on nothing but the sample rate.
  localparam logic [31:0] UI_HZ  = 32'(SAMPLE_HZ * UI_PER_FRAME);
  localparam logic [31:0] CLK_W  = 32'(CLK_FREQ_HZ);

  logic [31:0] acc_reg;
  logic [31:0] acc_next;
  logic [31:0] acc_sum;
  logic        wrap;

  assign acc_sum  = acc_reg + UI_HZ;
  assign wrap     = (acc_sum >= CLK_W);
  assign acc_next = wrap ? (acc_sum - CLK_W) : acc_sum;

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      acc_reg <= ACC_RESET;
      ui.tick <= 1'b0;
    end else begin
      acc_reg <= acc_next;
      ui.tick <= wrap;
    end
  end

endmodule
`default_nettype wire

// ==== ui_tick_if.sv ====
// Unit interval tick carried from the rate generator to the encoder.
`timescale 1ns/1ps
`default_nettype none
interface ui_tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input tick);
endinterface
`default_nettype wire
